//--- src/sio_pkg.sv
// Shared constants and types for the stream function units.
// Assumes one system clock shared by both ends of each stream link.
package sio_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned OP_LATENCY  = 3;
  localparam int unsigned STAT_LAT    = 1;
  localparam int unsigned WORD_W      = 32;
  localparam logic [1:0]  CNT_RESET   = 2'h0;
  localparam logic [7:0]  DATA_RESET  = 8'h00;

  typedef enum logic [1:0] {
    SIO_OP_NONE,
    SIO_OP_XFER,
    SIO_OP_STATUS
  } sio_op_t;

  typedef enum {
    SIO_IDLE,
    SIO_WAIT,
    SIO_BUSY
  } sio_state_t;
endpackage : sio_pkg

//--- src/sio_link_if.sv
// Stream link between a function unit and an external source or sink.
// Assumes both parties run on the same clock; no tristate wires.
`timescale 1ns/1ps
interface sio_link_if;
  import sio_pkg::*;
  logic [DATA_W-1:0] data;
  logic              strobe;
  logic              status;
  modport unit (input data, input status, output strobe);
  modport out_unit (output data, output strobe, input status);
  modport far (output data, output status, input strobe);
  modport far_sink (input data, input strobe, output status);
endinterface : sio_link_if

//--- src/sio_in_unit.sv
// Stream input function unit: reads a byte from an external source.
// Assumes op_start is a one-cycle pulse from the processor datapath and
// that the source is a synchronous device on clk_sys.
// Notes on behaviour
// [RL1] Read and write complete in three cycles
// [RL2] Status queries complete in one cycle
// [RL3] Input data port is eight bits
// [RL4] Read samples data and pulses acknowledge
// [RL5] Source presents next byte after acknowledge edge
// [RL6] Input status returns numeric one or zero
// [RL7] Source holds status high while data remains
// [RL8] Output data port presents written byte
// [RL9] Write automatically pulses data valid
// [RL10] Sink captures data only while valid high
// [RL11] Output status samples sink status port
// [RL12] Sink holds status high while space remains
// [RL13] Empty read or full write stalls processor
// [RL14] Each extra stream is a separate unit
// [RL15] Strobes are single-cycle pulses, low in reset
`timescale 1ns/1ps
module sio_in_unit #(
  parameter int unsigned LATENCY = sio_pkg::OP_LATENCY
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire sio_pkg::sio_op_t            op_start,
  output logic                             op_done,
  output logic [sio_pkg::WORD_W-1:0]       op_result,
  output logic                             stall,
  sio_link_if.unit                         link
);
  import sio_pkg::*;

  // Status is a far-end level on the same clock, still double-registered
  logic       status_meta;
  logic       status_sync;
  sio_state_t state;
  logic [1:0] cnt;
  logic       busy_read;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_meta <= 1'b0;
      status_sync <= 1'b0;
    end else begin
      status_meta <= link.status;
      status_sync <= status_meta;
    end
  end

  // One instance per source; the op name is bound outside this unit  [RL14]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state     <= SIO_IDLE;
      cnt       <= CNT_RESET;
      op_done   <= 1'b0;
      op_result <= '0;
      stall     <= 1'b0;
      busy_read <= 1'b0;
    end else begin
      op_done <= 1'b0;
      unique case (state)
        SIO_IDLE: begin
          if (op_start == SIO_OP_STATUS) begin
            op_done   <= 1'b1; // [RL2]
            op_result <= {{(WORD_W-1){1'b0}}, status_sync}; // [RL6]
          end else if (op_start == SIO_OP_XFER) begin
            if (status_sync) begin
              state     <= SIO_BUSY;
              cnt       <= 2'(LATENCY - 1);
              op_result <= {{(WORD_W-DATA_W){1'b0}}, link.data}; // [RL3] [RL4]
              busy_read <= 1'b1;
            end else begin
              state <= SIO_WAIT;
              stall <= 1'b1; // [RL13]
            end
          end
        end
        SIO_WAIT: begin
          if (status_sync) begin
            stall     <= 1'b0;
            state     <= SIO_BUSY;
            cnt       <= 2'(LATENCY - 1);
            op_result <= {{(WORD_W-DATA_W){1'b0}}, link.data}; // [RL4]
            busy_read <= 1'b1;
          end
        end
        SIO_BUSY: begin
          busy_read <= 1'b0;
          // Latency gives the source time to present the next byte  [RL5]
          if (cnt == 2'h1) begin
            state   <= SIO_IDLE;
            op_done <= 1'b1; // [RL1]
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
      endcase
    end
  end

  // Acknowledge: one pulse, registered from busy_read, in the second cycle after the edge that takes the byte  [RL15]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.strobe <= 1'b0;
    end else begin
      link.strobe <= busy_read;
    end
  end
endmodule : sio_in_unit

//--- src/sio_out_unit.sv
// Stream output function unit: writes a byte to an external sink.
// Assumes op_start is a one-cycle pulse and op_data stable with it.
`timescale 1ns/1ps
module sio_out_unit #(
  parameter int unsigned LATENCY = sio_pkg::OP_LATENCY
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire sio_pkg::sio_op_t            op_start,
  input  wire logic [sio_pkg::DATA_W-1:0]  op_data,
  output logic                             op_done,
  output logic [sio_pkg::WORD_W-1:0]       op_result,
  output logic                             stall,
  sio_link_if.out_unit                     link
);
  import sio_pkg::*;

  logic                status_meta;
  logic                status_sync;
  sio_state_t          state;
  logic [1:0]          cnt;
  logic [DATA_W-1:0]   held;
  logic                fire;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_meta <= 1'b0;
      status_sync <= 1'b0;
    end else begin
      status_meta <= link.status;
      status_sync <= status_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state     <= SIO_IDLE;
      cnt       <= CNT_RESET;
      op_done   <= 1'b0;
      op_result <= '0;
      stall     <= 1'b0;
      held      <= DATA_RESET;
      fire      <= 1'b0;
    end else begin
      op_done <= 1'b0;
      fire    <= 1'b0;
      unique case (state)
        SIO_IDLE: begin
          if (op_start == SIO_OP_STATUS) begin
            op_done   <= 1'b1; // [RL2]
            op_result <= {{(WORD_W-1){1'b0}}, status_sync}; // [RL11]
          end else if (op_start == SIO_OP_XFER) begin
            held <= op_data;
            if (status_sync) begin
              state <= SIO_BUSY;
              cnt   <= 2'(LATENCY - 1);
              fire  <= 1'b1; // [RL9]
            end else begin
              state <= SIO_WAIT;
              stall <= 1'b1; // [RL13]
            end
          end
        end
        SIO_WAIT: begin
          if (status_sync) begin
            stall <= 1'b0;
            state <= SIO_BUSY;
            cnt   <= 2'(LATENCY - 1);
            fire  <= 1'b1;
          end
        end
        SIO_BUSY: begin
          if (cnt == 2'h1) begin
            state   <= SIO_IDLE;
            op_done <= 1'b1; // [RL1]
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
      endcase
    end
  end

  // Data and valid leave together from flops; sink samples on valid  [RL10]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.strobe <= 1'b0;
      link.data   <= DATA_RESET;
    end else begin
      link.strobe <= fire; // [RL15]
      if (fire) begin
        link.data <= held; // [RL8]
      end
    end
  end
endmodule : sio_out_unit

//--- dv/sio_asserts.sv
// Checker for both stream links and the op handshakes.
// Assumes one clock; tb instantiates it beside the links.
`timescale 1ns/1ps
module sio_asserts (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire sio_pkg::sio_op_t in_op,
  input wire logic             in_done,
  input wire logic             in_ack,
  input wire logic             in_status,
  input wire sio_pkg::sio_op_t out_op,
  input wire logic             out_done,
  input wire logic             out_valid
);
  import sio_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Status is double-flopped, so a ready read needs status two cycles back
  sequence rd_go;
    in_op == SIO_OP_XFER && in_status && $past(in_status, 2);
  endsequence
  sequence rd_walk;
    !in_done ##1 in_ack && !in_done ##1 in_done;
  endsequence
  a_ack_pulse: assert property (in_ack |=> !in_ack)
    else $error("ack too wide");
  a_dv_pulse: assert property (out_valid |=> !out_valid)
    else $error("valid too wide");
  a_ack_done: assert property (in_ack |=> in_done)
    else $error("read done late");
  a_dv_done: assert property (out_valid |=> out_done)
    else $error("write done late");
  a_in_stat: assert property (in_op == SIO_OP_STATUS |=> in_done)
    else $error("in status slow");
  a_out_stat: assert property (out_op == SIO_OP_STATUS |=> out_done)
    else $error("out status slow");
  a_read_walk: assert property (rd_go |=> rd_walk)
    else $error("read walk wrong");
  a_rst_quiet: assert property ($past(rst) |-> !in_ack && !out_valid)
    else $error("strobe after reset");
endmodule : sio_asserts

//--- dv/tb.sv
// Bench: input and output units on two links, bench as source and sink.
// Assumes the units and link interface under src/.
`timescale 1ns/1ps
module tb;
  import sio_pkg::*;
  logic        clk_sys, rst, in_done, out_done, in_stall, out_stall, src_st, snk_st;
  sio_op_t     in_op, out_op;
  logic [7:0]  src = 8'h5A;
  logic [7:0]  cap = 8'hEE;
  logic [7:0]  out_dat, e;
  logic [31:0] in_res, out_res;
  logic [7:0]  wv [3] = '{8'h00, 8'hFF, 8'hC3};
  int          bad_count = 0, n_checks = 0, cyc = 0;
  sio_link_if in_l();
  sio_link_if out_l();
  assign in_l.data = src;
  assign in_l.status = src_st;
  assign out_l.status = snk_st;
  sio_in_unit u_sio_in_unit (.clk_sys(clk_sys), .rst(rst), .op_start(in_op),
    .op_done(in_done), .op_result(in_res), .stall(in_stall), .link(in_l.unit));
  sio_out_unit u_sio_out_unit (.clk_sys(clk_sys), .rst(rst), .op_start(out_op),
    .op_data(out_dat), .op_done(out_done), .op_result(out_res), .stall(out_stall),
    .link(out_l.out_unit));
  sio_asserts u_sio_asserts (.clk_sys(clk_sys), .rst(rst), .in_op(in_op), .in_done(in_done),
    .in_ack(in_l.strobe), .in_status(src_st), .out_op(out_op), .out_done(out_done),
    .out_valid(out_l.strobe));
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (in_l.strobe === 1'b1) src <= src + 8'h11;
    if (out_l.strobe === 1'b1) cap <= out_l.data;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input bit o, input sio_op_t k, input logic [7:0] d);
    @(posedge clk_sys);
    if (o) out_op <= k;
    else in_op <= k;
    if (o) out_dat <= d;
    @(posedge clk_sys);
    if (o) out_op <= SIO_OP_NONE;
    else in_op <= SIO_OP_NONE;
    do @(negedge clk_sys); while ((o ? out_done : in_done) !== 1'b1);
  endtask : go
  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    {rst, src_st, snk_st} = 3'h7;
    {in_op, out_op} = {SIO_OP_NONE, SIO_OP_NONE};
    {e, out_dat} = {8'h5A, 8'h00};
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Status passes two flops, so let it settle before the first op
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      go(0, SIO_OP_XFER, 8'h00);
      chk(in_res, {24'h0, e});
      e = e + 8'h11;
      go(1, SIO_OP_XFER, wv[i]);
      chk({24'h0, cap}, {24'h0, wv[i]});
    end
    go(0, SIO_OP_STATUS, 8'h00);
    chk(in_res, 32'h1);
    go(1, SIO_OP_STATUS, 8'h00);
    chk(out_res, 32'h1);
    @(posedge clk_sys);
    {src_st, snk_st} <= 2'h0;
    repeat (3) @(posedge clk_sys);
    go(0, SIO_OP_STATUS, 8'h00);
    chk(in_res, 32'h0);
    go(1, SIO_OP_STATUS, 8'h00);
    chk(out_res, 32'h0);
    // Empty source and full sink must both hold the ops back
    fork
      go(0, SIO_OP_XFER, 8'h00);
      go(1, SIO_OP_XFER, 8'h77);
      begin
        repeat (6) @(negedge clk_sys);
        chk({30'h0, in_stall, out_stall}, 32'h3);
        chk({24'h0, cap}, 32'hC3);
        @(posedge clk_sys);
        {src_st, snk_st} <= 2'h3;
      end
    join
    chk({24'h0, cap}, 32'h77);
    chk(in_res, {24'h0, e});
    end_sim();
  end
endmodule : tb
